// ### data_memory_and_table_read.sv
// Data memory map, indirect access, accumulator and table read path.
// Assumes the execution core issues one op per cycle and waits on stall.
`timescale 1ns/1ps
`include "data_memory_defs.svh"
module data_memory_and_table_read (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire data_memory_pkg::op_t      op,
    input  wire logic [7:0]                addr,
    input  wire logic [2:0]                bitSel,
    input  wire logic                      readToAcc,
    input  wire logic                      writeFromAlu,
    input  wire logic                      aluLoad,
    input  wire logic [7:0]                aluResult,
    input  wire logic [11:0]               pc,
    input  wire logic                      pagePointerEnable,
    input  wire logic [14:0]               romData,
    output logic      [7:0]                readData,
    output logic      [7:0]                accumulator,
    output logic      [11:0]               romAddr,
    output logic                           stall,
    output logic                           pclLoad,
    output logic      [7:0]                pclData
);

    // ****************************************************************
    // Address decode helpers
    // ****************************************************************
    function automatic logic isGp(input logic [8:0] a);
        isGp = (a[8] == 1'b0) && (a[7:0] >= `GP_BASE) && (a < `GP_LIMIT);
    endfunction : isGp

    function automatic logic isIndirect(input logic [7:0] a);
        isIndirect = (a == `ADDR_INDIRECT_PORT_FIRST) ||
                     (a == `ADDR_INDIRECT_PORT_SECOND);
    endfunction : isIndirect

    function automatic logic [7:0] gpIndex(input logic [8:0] a);
        gpIndex = 8'(a[7:0] - `GP_BASE);
    endfunction : gpIndex

    function automatic logic [7:0] bitMaskOf(input logic [2:0] b);
        bitMaskOf = 8'(8'h01 << b);
    endfunction : bitMaskOf

    // ****************************************************************
    // State
    // ****************************************************************
    data_memory_pkg::table_state_t state_q, state_d;
    logic [7:0]  mp0_q, mp0_d;
    logic [7:0]  mp1_q, mp1_d;
    logic        bank_q, bank_d;
    logic [7:0]  tblp_q, tblp_d;
    logic [7:0]  table_page_select_q, table_page_select_d;
    logic [7:0]  table_high_byte_q, table_high_byte_d;
    logic [7:0]  acc_q, acc_d;
    logic [7:0]  readData_q, readData_d;
    logic [11:0] romAddr_q, romAddr_d;
    logic        stall_q, stall_d;
    logic        pclLoad_q, pclLoad_d;
    logic [7:0]  pclData_q, pclData_d;
    logic [8:0]  dest_q, dest_d;

    logic [8:0]  effAddr;
    logic [7:0]  rdMux;
    logic [7:0]  ramRdata;
    logic [7:0]  ramIndex;
    logic        ramWe;
    logic [7:0]  ramWdata;
    logic        wrEn;
    logic [8:0]  wrAddr;
    logic [7:0]  wrData;
    logic [11:0] tableAddr;
    logic [7:0]  bitMask;
    logic        tableLast;

    // ****************************************************************
    // Indirect resolution
    // ****************************************************************
    always_comb begin
        if (addr == `ADDR_INDIRECT_PORT_FIRST) begin
            effAddr = {1'b0, mp0_q};
        end else if (addr == `ADDR_INDIRECT_PORT_SECOND) begin
            effAddr = {bank_q, mp1_q};
        end else begin
            effAddr = {1'b0, addr};
        end
        // A pointer aimed at a port lands on a null slot
        if (isIndirect(addr) && isIndirect(effAddr[7:0])) begin
            effAddr = `NULL_ADDR;
        end
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always_comb begin
        rdMux = `RESET_BYTE;
        if (isGp(effAddr)) begin
            rdMux = ramRdata;
        end else if (effAddr[8] == 1'b0) begin
            case (effAddr[7:0])
                `ADDR_MEMORY_POINTER_FIRST:  rdMux = mp0_q;
                `ADDR_MEMORY_POINTER_SECOND: rdMux = mp1_q;
                `ADDR_BANK_SELECT:           rdMux = {7'h00, bank_q};
                `ADDR_ACCUMULATOR:           rdMux = acc_q;
                `ADDR_PROGRAM_COUNTER_LOW:   rdMux = pc[7:0];
                `ADDR_TABLE_POINTER:         rdMux = tblp_q;
                `ADDR_TABLE_HIGH_BYTE:       rdMux = table_high_byte_q;
                `ADDR_TABLE_PAGE_SELECT:     rdMux = table_page_select_q;
                default:                     rdMux = `RESET_BYTE;
            endcase
        end
    end

    // ****************************************************************
    // Table address
    // ****************************************************************
    assign tableLast = (op == data_memory_pkg::OP_TBL_LAST);

    table_address_gen u_tag (
        .lastPage          (tableLast),
        .pagePointerEnable (pagePointerEnable),
        .pcPage            (pc[11:8]),
        .pageSelect        (table_page_select_q[3:0]),
        .pointer           (tblp_q),
        .romAddr           (tableAddr)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_d    = state_q;
        mp0_d      = mp0_q;
        mp1_d      = mp1_q;
        bank_d     = bank_q;
        tblp_d     = tblp_q;
        table_page_select_d     = table_page_select_q;
        table_high_byte_d     = table_high_byte_q;
        acc_d      = acc_q;
        readData_d = readData_q;
        romAddr_d  = romAddr_q;
        stall_d    = stall_q;
        pclLoad_d  = 1'b0;
        pclData_d  = pclData_q;
        dest_d     = dest_q;
        wrEn       = 1'b0;
        wrAddr     = effAddr;
        wrData     = acc_q;
        ramWe      = 1'b0;
        bitMask    = bitMaskOf(bitSel);

        if (aluLoad) begin
            acc_d = aluResult;
        end

        case (state_q)
            data_memory_pkg::TS_IDLE: begin
                case (op)
                    data_memory_pkg::OP_READ: begin
                        readData_d = rdMux;
                        if (readToAcc) begin
                            acc_d = rdMux;
                        end
                    end
                    data_memory_pkg::OP_WRITE: begin
                        wrEn   = 1'b1;
                        // Only the accumulator or ALU feeds a write
                        wrData = writeFromAlu ? aluResult : acc_q;
                    end
                    data_memory_pkg::OP_BITSET: begin
                        wrEn   = 1'b1;
                        wrData = rdMux | bitMask;
                    end
                    data_memory_pkg::OP_BITCLR: begin
                        wrEn   = 1'b1;
                        wrData = rdMux & ~bitMask;
                    end
                    data_memory_pkg::OP_TBL_CUR,
                    data_memory_pkg::OP_TBL_LAST: begin
                        dest_d    = effAddr;
                        romAddr_d = tableAddr;
                        stall_d   = 1'b1;
                        state_d   = data_memory_pkg::TS_FETCH;
                    end
                    default: begin
                    end
                endcase
            end
            data_memory_pkg::TS_FETCH: begin
                wrEn    = 1'b1;
                // Target was resolved at issue; pointer edits cannot move it
                wrAddr  = dest_q;
                wrData  = romData[7:0];
                table_high_byte_d  = {1'b0, romData[14:8]};
                stall_d = 1'b0;
                state_d = data_memory_pkg::TS_IDLE;
            end
            default: begin
                stall_d = 1'b0;
                state_d = data_memory_pkg::TS_IDLE;
            end
        endcase

        // Read-only and unused slots leave all state alone
        if (wrEn) begin
            if (isGp(wrAddr)) begin
                ramWe = 1'b1;
            end else if (wrAddr[8] == 1'b0) begin
                case (wrAddr[7:0])
                    `ADDR_MEMORY_POINTER_FIRST:  mp0_d  = wrData;
                    `ADDR_MEMORY_POINTER_SECOND: mp1_d  = wrData;
                    `ADDR_BANK_SELECT:
                        bank_d = wrData[`BANK_FIELD_MSB];
                    `ADDR_ACCUMULATOR:           acc_d  = wrData;
                    `ADDR_TABLE_POINTER:         tblp_d = wrData;
                    `ADDR_TABLE_PAGE_SELECT:     table_page_select_d = wrData;
                    `ADDR_PROGRAM_COUNTER_LOW: begin
                        pclLoad_d = 1'b1;
                        pclData_d = wrData;
                    end
                    `ADDR_TABLE_HIGH_BYTE: begin
                        // Only a table fetch may load it
                    end
                    `ADDR_INDIRECT_PORT_FIRST,
                    `ADDR_INDIRECT_PORT_SECOND: begin
                        // Ports resolve to their pointers before this point
                    end
                    default: begin
                        // Unused and reserved slots drop the write
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // General purpose array port
    // ****************************************************************
    always_comb begin
        ramIndex = gpIndex(wrAddr);
        ramWdata = wrData;
        // One shared index: writes take it, reads use it otherwise
        if (!wrEn) begin
            ramIndex = gpIndex(effAddr);
        end
    end

    gp_ram u_ram (
        .clk   (clk),
        .we    (ramWe),
        .index (ramIndex),
        .wdata (ramWdata),
        .rdata (ramRdata)
    );

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q    <= data_memory_pkg::TS_IDLE;
            mp0_q      <= `RESET_BYTE;
            mp1_q      <= `RESET_BYTE;
            bank_q     <= 1'b0;
            tblp_q     <= `RESET_BYTE;
            table_page_select_q     <= `RESET_BYTE;
            table_high_byte_q     <= `RESET_BYTE;
            acc_q      <= `RESET_BYTE;
            readData_q <= `RESET_BYTE;
            romAddr_q  <= 12'h000;
            stall_q    <= 1'b0;
            pclLoad_q  <= 1'b0;
            pclData_q  <= `RESET_BYTE;
            dest_q     <= 9'h000;
        end else begin
            state_q    <= state_d;
            mp0_q      <= mp0_d;
            mp1_q      <= mp1_d;
            bank_q     <= bank_d;
            tblp_q     <= tblp_d;
            table_page_select_q     <= table_page_select_d;
            table_high_byte_q     <= table_high_byte_d;
            acc_q      <= acc_d;
            readData_q <= readData_d;
            romAddr_q  <= romAddr_d;
            stall_q    <= stall_d;
            pclLoad_q  <= pclLoad_d;
            pclData_q  <= pclData_d;
            dest_q     <= dest_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign readData    = readData_q;
    assign accumulator = acc_q;
    assign romAddr     = romAddr_q;
    assign stall       = stall_q;
    assign pclLoad     = pclLoad_q;
    assign pclData     = pclData_q;

endmodule : data_memory_and_table_read

// ### data_memory_and_table_read_tb_top.sv
// Self-checking testbench for the data memory block.
// Assumes the checker file is compiled alongside; it binds itself.
`timescale 1ns/1ps
`include "data_memory_defs.svh"
module data_memory_and_table_read_tb_top;
    logic                 clk = 0;
    logic                 reset;
    data_memory_pkg::op_t op;
    logic [7:0]           addr, aluResult, readData, accumulator, pclData;
    logic [2:0]           bitSel;
    logic                 readToAcc, writeFromAlu, aluLoad, stall, pclLoad;
    logic                 pagePointerEnable, hit;
    logic [11:0]          pc, romAddr;
    logic [14:0]          romData, w;
    logic [7:0]           expQ[$];
    logic [7:0]           a, v, p, m;
    int                   miscompares, checks, i;
    logic [14:0]          e;
    logic [7:0]           sfrList [7] = '{8'h01, 8'h03, 8'h04, 8'h05,
                                          8'h07, 8'h08, 8'h1f};
    logic [7:0]           unusedList [6] = '{8'h09, 8'h1e, 8'h20,
                                             8'h3f, 8'he0, 8'hff};

    data_memory_and_table_read uut (.clk, .reset, .op, .addr, .bitSel,
        .readToAcc, .writeFromAlu, .aluLoad, .aluResult, .pc,
        .pagePointerEnable, .romData, .readData, .accumulator, .romAddr,
        .stall, .pclLoad, .pclData);

    always #10 clk = ~clk;

    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string name, input logic [14:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task give_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // Ops are spaced by an idle cycle so no input changes twice at once
    task issue(input data_memory_pkg::op_t o, input logic [7:0] ad, d);
        op = o;
        addr = ad;
        aluResult = d;
        @(posedge clk);
        #1 op = data_memory_pkg::OP_NONE;
        @(posedge clk);
        #1;
    endtask : issue

    task wr(input logic [7:0] ad, d);
        issue(data_memory_pkg::OP_WRITE, ad, d);
    endtask : wr

    task rd(input logic [7:0] ad, e);
        expQ.push_back(e);
        issue(data_memory_pkg::OP_READ, ad, 8'h00);
    endtask : rd

    // An op offered in the stall cycle must be dropped
    task tbl(input data_memory_pkg::op_t o, input logic [7:0] d,
             input logic [11:0] ra);
        w = 15'($urandom);
        op = o;
        addr = d;
        @(posedge clk);
        #1 op = data_memory_pkg::OP_WRITE;
        addr = 8'h48;
        aluResult = 8'hee;
        chk("stall", stall, 15'h0001);
        chk("romAddr", romAddr, ra);
        romData = w;
        // Look one step after each edge so stall has settled
        for (i = 0; i < 3 && stall !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        op = data_memory_pkg::OP_NONE;
        chk("stall", stall, 15'h0000);
        romData = ~w;
        rd(d, w[7:0]);
        // High byte is read back before any other table op reuses it
        rd(`ADDR_TABLE_HIGH_BYTE, {1'b0, w[14:8]});
        rd(8'h48, 8'h11);
    endtask : tbl

    // ****************************************
    // Read result watcher
    // ****************************************
    always @(posedge clk) begin
        hit = (op === data_memory_pkg::OP_READ);
        #2;
        if (hit) begin
            // An empty queue can never match an eight-bit read
            e = expQ.size() ? {7'h00, expQ.pop_front()} : 15'h7fff;
            chk("readData", readData, e);
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reset, readToAcc, writeFromAlu} = 3'b101;
        {aluLoad, aluResult, bitSel, pagePointerEnable} = '0;
        {addr, pc, romData} = '0;
        op = data_memory_pkg::OP_NONE;
        v = 8'($urandom(32'h31765428));
        repeat (5) @(posedge clk);
        #1 reset = 0;
        @(posedge clk);
        #1;
        foreach (sfrList[k])
            rd(sfrList[k], 8'h00);
        $display("test reset done");
        for (int n = 0; n < 6; n++) begin
            a = n == 0 ? `GP_BASE : n == 1 ? 8'hdf
                : 8'h40 + 8'($urandom % 160);
            v = 8'($urandom);
            bitSel = 3'($urandom);
            m = 8'h01 << bitSel;
            wr(a, v);
            rd(a, v);
            issue(data_memory_pkg::OP_BITSET, a, 8'h00);
            rd(a, v | m);
            issue(data_memory_pkg::OP_BITCLR, a, 8'h00);
            rd(a, v & ~m);
        end
        p = 8'($urandom);
        aluLoad = 1;
        aluResult = p;
        @(posedge clk);
        #1 aluLoad = 0;
        chk("accumulator", accumulator, p);
        writeFromAlu = 0;
        wr(8'h50, 8'h00);
        writeFromAlu = 1;
        rd(8'h50, p);
        wr(8'h51, v);
        readToAcc = 1;
        rd(8'h51, v);
        readToAcc = 0;
        chk("accumulator", accumulator, v);
        $display("test general memory done");
        foreach (unusedList[k]) begin
            wr(unusedList[k], 8'ha5);
            rd(unusedList[k], 8'h00);
        end
        wr(`ADDR_TABLE_HIGH_BYTE, 8'hff);
        rd(`ADDR_TABLE_HIGH_BYTE, 8'h00);
        $display("test unused done");
        wr(8'h01, 8'h60);
        rd(8'h01, 8'h60);
        wr(8'h00, v);
        rd(8'h60, v);
        wr(8'h03, 8'h61);
        wr(8'h02, p);
        rd(8'h61, p);
        wr(8'h04, 8'h01);
        rd(8'h02, 8'h00);
        rd(8'h00, v);
        wr(8'h02, 8'h3c);
        wr(8'h04, 8'h00);
        rd(8'h02, p);
        wr(8'h01, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h77);
        rd(8'h01, 8'h00);
        wr(8'h03, 8'h02);
        rd(8'h02, 8'h00);
        $display("test indirect done");
        pc = 12'($urandom);
        op = data_memory_pkg::OP_WRITE;
        addr = `ADDR_PROGRAM_COUNTER_LOW;
        aluResult = v;
        @(posedge clk);
        #1 op = data_memory_pkg::OP_NONE;
        chk("pclLoad", pclLoad, 15'h0001);
        chk("pclData", pclData, v);
        @(posedge clk);
        #1 chk("pclLoad", pclLoad, 15'h0000);
        rd(`ADDR_PROGRAM_COUNTER_LOW, pc[7:0]);
        $display("test jump done");
        wr(8'h48, 8'h11);
        wr(`ADDR_TABLE_POINTER, 8'h06);
        tbl(data_memory_pkg::OP_TBL_LAST, 8'h70, 12'hf06);
        pc = 12'h5a3;
        wr(`ADDR_TABLE_POINTER, p);
        tbl(data_memory_pkg::OP_TBL_CUR, 8'h71, {4'h5, p});
        pagePointerEnable = 1;
        wr(`ADDR_TABLE_PAGE_SELECT, 8'hc9);
        tbl(data_memory_pkg::OP_TBL_CUR, 8'h72, {4'h9, p});
        wr(`ADDR_TABLE_HIGH_BYTE, 8'h00);
        rd(`ADDR_TABLE_HIGH_BYTE, {1'b0, w[14:8]});
        $display("test table done");
        give_verdict();
    end
endmodule : data_memory_and_table_read_tb_top

// ### data_memory_defs.svh
// Address map, field positions and reset values for the data memory block.
// Assumes inclusion by every design file that decodes data memory.
`ifndef DATA_MEMORY_DEFS_SVH
`define DATA_MEMORY_DEFS_SVH

// ****************************************************************
// Special purpose addresses
// ****************************************************************
`define ADDR_INDIRECT_PORT_FIRST   8'h00
`define ADDR_MEMORY_POINTER_FIRST  8'h01
`define ADDR_INDIRECT_PORT_SECOND  8'h02
`define ADDR_MEMORY_POINTER_SECOND 8'h03
`define ADDR_BANK_SELECT           8'h04
`define ADDR_ACCUMULATOR           8'h05
`define ADDR_PROGRAM_COUNTER_LOW   8'h06
`define ADDR_TABLE_POINTER         8'h07
`define ADDR_TABLE_HIGH_BYTE       8'h08
`define ADDR_TABLE_PAGE_SELECT     8'h1f

// ****************************************************************
// General purpose area and banking
// ****************************************************************
`define GP_BASE        8'h40
`define GP_DEPTH       160
`define GP_LIMIT       9'h0e0
`define NULL_ADDR      9'h1ff
`define BANK_FIELD_MSB 0

// ****************************************************************
// Program memory and reset values
// ****************************************************************
`define LAST_PAGE_BITS 4'hf
`define ROM_WIDTH      15
`define RESET_BYTE     8'h00

`endif

// ### data_memory_monitor.sv
// Concurrent checks on the data memory block top-level ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`include "data_memory_defs.svh"
module data_memory_monitor (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire data_memory_pkg::op_t op,
    input wire logic [7:0]           addr,
    input wire logic [2:0]           bitSel,
    input wire logic                 readToAcc,
    input wire logic                 writeFromAlu,
    input wire logic                 aluLoad,
    input wire logic [7:0]           aluResult,
    input wire logic [11:0]          pc,
    input wire logic                 pagePointerEnable,
    input wire logic [14:0]          romData,
    input wire logic [7:0]           readData,
    input wire logic [7:0]           accumulator,
    input wire logic [11:0]          romAddr,
    input wire logic                 stall,
    input wire logic                 pclLoad,
    input wire logic [7:0]           pclData
);
    // ****************************************
    // Helpers
    // ****************************************
    logic       isTbl;
    logic       isRd;
    logic       isJumpWr;
    logic       isUnused;
    logic [3:0] pcPage;
    logic [7:0] wData;
    assign isTbl    = !stall && (op == data_memory_pkg::OP_TBL_CUR
                      || op == data_memory_pkg::OP_TBL_LAST);
    assign isRd     = !stall && op == data_memory_pkg::OP_READ;
    assign isJumpWr = !stall && op == data_memory_pkg::OP_WRITE
                      && addr == `ADDR_PROGRAM_COUNTER_LOW;
    assign isUnused = (addr > 8'h08 && addr < 8'h1f)
                      || (addr > 8'h1f && addr < `GP_BASE) || addr >= 8'he0;
    assign pcPage   = pc[11:8];
    assign wData    = writeFromAlu ? aluResult : accumulator;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ****************************************
    // Assertions
    // ****************************************
    sequence tblTaken;
        isTbl;
    endsequence
    sequence stallPulse;
        stall ##1 !stall;
    endsequence

    AST_STALL_PULSE: assert property (tblTaken |=> stallPulse)
        else $error("stall is not a single cycle after a table op");
    AST_LAST_PAGE: assert property (
        isTbl && op == data_memory_pkg::OP_TBL_LAST
        |=> romAddr[11:8] == 4'hf)
        else $error("last page table address not in last page");
    AST_CUR_PAGE: assert property (
        isTbl && !pagePointerEnable && op == data_memory_pkg::OP_TBL_CUR
        |=> romAddr[11:8] == $past(pcPage))
        else $error("current page table address wrong page");
    AST_ROM_HOLD: assert property (!isTbl |=> $stable(romAddr))
        else $error("table address moved without a table op");
    AST_JUMP_DATA: assert property (
        isJumpWr |=> pclLoad && pclData == $past(wData))
        else $error("program counter low write not passed on");
    AST_JUMP_CAUSE: assert property (pclLoad |-> $past(isJumpWr))
        else $error("program counter load without a write");
    AST_ACC_ALU: assert property (
        aluLoad && op == data_memory_pkg::OP_NONE
        |=> accumulator == $past(aluResult))
        else $error("accumulator missed the ALU result");
    AST_READ_ACC: assert property (
        isRd && readToAcc && !aluLoad |=> accumulator == readData)
        else $error("read into accumulator disagrees with read data");
    AST_NULL_READ: assert property (
        isRd && isUnused |=> readData == 8'h00)
        else $error("unused location read not zero");
    AST_HIGH_TOP: assert property (
        isRd && addr == `ADDR_TABLE_HIGH_BYTE |=> !readData[7])
        else $error("table high byte top bit set");
endmodule : data_memory_monitor

bind data_memory_and_table_read data_memory_monitor mon (.clk, .reset, .op,
    .addr, .bitSel, .readToAcc, .writeFromAlu, .aluLoad, .aluResult, .pc,
    .pagePointerEnable, .romData, .readData, .accumulator, .romAddr, .stall,
    .pclLoad, .pclData);

// ### data_memory_pkg.sv
// Types shared by the data memory block.
// Assumes the core encodes one operation per cycle with op_t.
package data_memory_pkg;

    typedef enum logic [2:0] {
        OP_NONE      = 3'b000,
        OP_READ      = 3'b001,
        OP_WRITE     = 3'b010,
        OP_BITSET    = 3'b011,
        OP_BITCLR    = 3'b100,
        OP_TBL_CUR   = 3'b101,
        OP_TBL_LAST  = 3'b110
    } op_t;

    typedef enum logic [1:0] {
        TS_IDLE  = 2'b00,
        TS_FETCH = 2'b01
    } table_state_t;

endpackage : data_memory_pkg

// ### gp_ram.sv
// General purpose data memory array, write on the clock, read at once.
// Assumes the caller only writes indices inside the array.
`timescale 1ns/1ps
`include "data_memory_defs.svh"
module gp_ram (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [7:0] index,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    logic [7:0] mem [`GP_DEPTH];

    // No reset: the array is volatile and holds garbage until written
    always_ff @(posedge clk) begin
        if (we) begin
            mem[index] <= wdata;
        end
    end

    always_comb begin
        rdata = mem[index];
    end

endmodule : gp_ram

// ### table_address_gen.sv
// Program memory address generator for table reads.
// Assumes pointer, page and program counter come from the same clock.
`timescale 1ns/1ps
`include "data_memory_defs.svh"
module table_address_gen (
    input  wire logic        lastPage,
    input  wire logic        pagePointerEnable,
    input  wire logic [3:0]  pcPage,
    input  wire logic [3:0]  pageSelect,
    input  wire logic [7:0]  pointer,
    output logic      [11:0] romAddr
);
    logic [3:0] page;

    always_comb begin
        if (lastPage) begin
            page = `LAST_PAGE_BITS;
        end else if (pagePointerEnable) begin
            page = pageSelect;
        end else begin
            page = pcPage;
        end
        romAddr = {page, pointer};
    end

endmodule : table_address_gen
